// *** hw/otfs_top.sv ***
// Output terminal function select, polarity and parameter registers
`timescale 1ns/10ps
`default_nettype none
module otfs_top #(
  parameter int unsigned MS_CYCLES = otfs_pkg::MS_CYCLES,
  parameter int unsigned FW = otfs_pkg::FREQ_W
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // Parameter access port
  input wire logic i_par_wr,
  input wire logic i_par_rd,
  input wire logic [15:0] i_par_addr,
  input wire logic [15:0] i_par_wdata,
  output logic [15:0] o_par_rdata,
  output logic o_par_ack,
  output logic o_par_err,
  // Drive status
  input wire logic i_run,
  input wire logic i_reverse,
  input wire logic i_fault,
  input wire logic i_fault_recovery,
  input wire logic i_external_fault_trip,
  input wire logic i_undervoltage,
  input wire logic i_bus_voltage_ok,
  input wire logic i_run_inhibit,
  input wire logic [FW-1:0] i_out_freq,
  input wire logic [FW-1:0] i_set_freq,
  input wire logic [FW-1:0] i_freq_upper_limit,
  input wire logic [FW-1:0] i_freq_lower_limit,
  input wire logic [FW-1:0] i_freq_threshold_one_value,
  input wire logic [FW-1:0] i_freq_threshold_one_hysteresis,
  input wire logic [FW-1:0] i_freq_threshold_two_value,
  input wire logic [FW-1:0] i_freq_threshold_two_hysteresis,
  input wire logic [FW-1:0] i_arrival_band_width,
  input wire logic i_prog_cycle_done,
  input wire logic i_prog_phase_done,
  input wire logic i_fb_over_upper,
  input wire logic i_fb_under_lower,
  input wire logic [15:0] i_feedback_loss_detect_time,
  input wire logic i_fb_sensor_broken,
  input wire logic i_timer_reached,
  input wire logic i_count_clk,
  input wire logic [15:0] i_counter_max_value,
  // Terminals
  output logic o_main_transistor_on,
  output logic o_ext_transistor_on,
  output logic o_relay_make_contact,
  output logic o_relay_break_contact,
  output logic o_relay_two_make_contact,
  output logic o_relay_two_break_contact
);
  logic [15:0] pol_r;
  logic [15:0] main_fn_r;
  logic [15:0] rly1_fn_r;
  logic [15:0] ext_fn_r;
  logic [15:0] rly2_fn_r;
  logic [15:0] rdata_r;
  logic ack_r;
  logic err_r;
  logic hit_pol;
  logic hit_main;
  logic hit_rly1;
  logic hit_ext;
  logic hit_rly2;
  logic hit_any;
  logic pol_ok_w;
  logic fn_ok_w;
  logic val_ok_w;
  logic [15:0] rdata_w;
  logic [3:0] pol_w;

  // Address hits and write value checks
  assign hit_pol = (i_par_addr == otfs_pkg::ADDR_POL);
  assign hit_main = (i_par_addr == otfs_pkg::ADDR_MAIN);
  assign hit_rly1 = (i_par_addr == otfs_pkg::ADDR_RLY1);
  assign hit_ext = (i_par_addr == otfs_pkg::ADDR_EXT);
  assign hit_rly2 = (i_par_addr == otfs_pkg::ADDR_RLY2);
  assign hit_any = hit_pol | hit_main | hit_rly1 | hit_ext | hit_rly2;
  assign pol_ok_w = otfs_pkg::pol_ok(i_par_wdata);
  assign fn_ok_w = (i_par_wdata <= otfs_pkg::FUNC_MAX);
  assign val_ok_w = hit_pol ? pol_ok_w : fn_ok_w;
  assign pol_w = otfs_pkg::pol_bits(pol_r);

  // Read selection
  always_comb begin
    if (hit_pol) begin
      rdata_w = pol_r;
    end else if (hit_main) begin
      rdata_w = main_fn_r;
    end else if (hit_rly1) begin
      rdata_w = rly1_fn_r;
    end else if (hit_ext) begin
      rdata_w = ext_fn_r;
    end else if (hit_rly2) begin
      rdata_w = rly2_fn_r;
    end else begin
      rdata_w = 16'h0000;
    end
  end

  // Setting registers; illegal values are refused and kept
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      pol_r <= otfs_pkg::RST_POL;
      main_fn_r <= otfs_pkg::RST_MAIN;
      rly1_fn_r <= otfs_pkg::RST_RLY1;
      ext_fn_r <= otfs_pkg::RST_EXT;
      rly2_fn_r <= otfs_pkg::RST_RLY2;
    end else if (i_par_wr && val_ok_w) begin
      if (hit_pol) pol_r <= i_par_wdata;
      if (hit_main) main_fn_r <= i_par_wdata;
      if (hit_rly1) rly1_fn_r <= i_par_wdata;
      if (hit_ext) ext_fn_r <= i_par_wdata;
      if (hit_rly2) rly2_fn_r <= i_par_wdata;
    end
  end

  // Access answer one cycle after the strobe
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      ack_r <= i_par_wr | i_par_rd;
      err_r <= (i_par_wr | i_par_rd) & (!hit_any | (i_par_wr & !val_ok_w));
      if (i_par_rd) rdata_r <= rdata_w;
    end
  end

  assign o_par_ack = ack_r;
  assign o_par_err = err_r;
  assign o_par_rdata = rdata_r;

  // Millisecond timebase
  logic [31:0] ms_cnt_r;
  logic ms_tick_r;
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      ms_cnt_r <= 32'h0000_0000;
      ms_tick_r <= 1'b0;
    end else begin
      ms_tick_r <= (ms_cnt_r == 32'(MS_CYCLES - 1));
      ms_cnt_r <= (ms_cnt_r == 32'(MS_CYCLES - 1)) ? 32'h0000_0000 : ms_cnt_r + 32'h0000_0001;
    end
  end

  // Feedback alarm persistence timers in milliseconds
  logic [15:0] fb_hi_cnt_r;
  logic [15:0] fb_lo_cnt_r;
  logic fb_hi_w;
  logic fb_lo_w;
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || !i_fb_over_upper) begin
      fb_hi_cnt_r <= 16'h0000;
    end else if (ms_tick_r && fb_hi_cnt_r != 16'hFFFF) begin
      fb_hi_cnt_r <= fb_hi_cnt_r + 16'h0001;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || !i_fb_under_lower) begin
      fb_lo_cnt_r <= 16'h0000;
    end else if (ms_tick_r && fb_lo_cnt_r != 16'hFFFF) begin
      fb_lo_cnt_r <= fb_lo_cnt_r + 16'h0001;
    end
  end
  assign fb_hi_w = i_fb_over_upper && (fb_hi_cnt_r >= i_feedback_loss_detect_time);
  assign fb_lo_w = i_fb_under_lower && (fb_lo_cnt_r >= i_feedback_loss_detect_time);

  // External count clock: two-stage synchroniser, then edge detect
  logic cclk_s1_r;
  logic cclk_s2_r;
  logic cclk_s3_r;
  logic cclk_rise_w;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic cnt_pulse_r;
  logic cnt_wrap_w;
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      cclk_s1_r <= 1'b0;
      cclk_s2_r <= 1'b0;
      cclk_s3_r <= 1'b0;
    end else begin
      cclk_s1_r <= i_count_clk;
      cclk_s2_r <= cclk_s1_r;
      cclk_s3_r <= cclk_s2_r;
    end
  end
  assign cclk_rise_w = cclk_s2_r & ~cclk_s3_r;
  assign cnt_nxt = cnt_r + 16'h0001;
  assign cnt_wrap_w = (i_counter_max_value != 16'h0000) && (cnt_nxt >= i_counter_max_value);

  // Counter wraps to zero at maximum; pulse holds for one count period
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      cnt_r <= 16'h0000;
      cnt_pulse_r <= 1'b0;
    end else if (cclk_rise_w) begin
      cnt_r <= cnt_wrap_w ? 16'h0000 : cnt_nxt;
      cnt_pulse_r <= cnt_wrap_w;
    end
  end

  // Frequency comparisons
  logic freq_threshold_one_w;
  logic freq_threshold_two_w;
  logic [FW-1:0] freq_diff_w;
  logic arrive_w;
  otfs_freq_detect #(.FW(FW)) u_freq_threshold_one (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_freq(i_out_freq),
    .i_level(i_freq_threshold_one_value),
    .i_hyst(i_freq_threshold_one_hysteresis),
    .o_on(freq_threshold_one_w)
  );
  otfs_freq_detect #(.FW(FW)) u_freq_threshold_two (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_freq(i_out_freq),
    .i_level(i_freq_threshold_two_value),
    .i_hyst(i_freq_threshold_two_hysteresis),
    .o_on(freq_threshold_two_w)
  );
  assign freq_diff_w = (i_out_freq >= i_set_freq) ? (i_out_freq - i_set_freq)
                                                  : (i_set_freq - i_out_freq);
  assign arrive_w = (freq_diff_w <= i_arrival_band_width);

  // Fixed-width event pulses
  logic cycle_p_w;
  logic phase_p_w;
  logic timer_p_w;
  otfs_pulse #(.WIDTH_MS(otfs_pkg::PROG_PULSE_MS)) u_cycle (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_trig(i_prog_cycle_done),
    .i_ms_tick(ms_tick_r),
    .o_active(cycle_p_w)
  );
  otfs_pulse #(.WIDTH_MS(otfs_pkg::PROG_PULSE_MS)) u_phase (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_trig(i_prog_phase_done),
    .i_ms_tick(ms_tick_r),
    .o_active(phase_p_w)
  );
  otfs_pulse #(.WIDTH_MS(otfs_pkg::TIMER_PULSE_MS)) u_timer (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_trig(i_timer_reached),
    .i_ms_tick(ms_tick_r),
    .o_active(timer_p_w)
  );

  // Condition vector indexed by function code; unlisted codes stay 0
  logic [63:0] cond_w;
  always_comb begin
    cond_w = 64'h0000_0000_0000_0000;
    cond_w[otfs_pkg::FN_RUN] = i_run;
    cond_w[otfs_pkg::FN_REV] = i_run & i_reverse;
    cond_w[otfs_pkg::FN_FWD] = i_run & ~i_reverse;
    cond_w[otfs_pkg::FN_FLT_ALL] = i_fault | i_fault_recovery;
    cond_w[otfs_pkg::FN_FLT_NR] = i_fault & ~i_fault_recovery;
    cond_w[otfs_pkg::FN_EXT_FLT] = i_external_fault_trip;
    cond_w[otfs_pkg::FN_UV] = i_undervoltage;
    cond_w[otfs_pkg::FN_READY] = ~i_fault & i_bus_voltage_ok & ~i_run_inhibit;
    cond_w[otfs_pkg::FN_FREQ_THRESHOLD_ONE] = freq_threshold_one_w;
    cond_w[otfs_pkg::FN_FREQ_THRESHOLD_TWO] = freq_threshold_two_w;
    cond_w[otfs_pkg::FN_ARRIVE] = arrive_w;
    cond_w[otfs_pkg::FN_ZERO] = i_run & (i_out_freq == '0);
    cond_w[otfs_pkg::FN_UPPER] = i_run & (i_out_freq == i_freq_upper_limit);
    cond_w[otfs_pkg::FN_LOWER] = i_run & (i_out_freq == i_freq_lower_limit);
    cond_w[otfs_pkg::FN_CYCLE] = cycle_p_w;
    cond_w[otfs_pkg::FN_PHASE] = phase_p_w;
    cond_w[otfs_pkg::FN_FB_HI] = fb_hi_w;
    cond_w[otfs_pkg::FN_FB_LO] = fb_lo_w;
    cond_w[otfs_pkg::FN_FB_LOSS] = i_fb_sensor_broken;
    cond_w[otfs_pkg::FN_TIMER] = timer_p_w;
    cond_w[otfs_pkg::FN_CNT_MAX] = cnt_pulse_r;
  end

  // Per-terminal selection, then polarity
  logic [5:0] code_w [otfs_pkg::N_TERM];
  logic [3:0] lvl_w;
  logic [3:0] def_w;
  assign code_w[otfs_pkg::T_MAIN] = main_fn_r[5:0];
  assign code_w[otfs_pkg::T_RLY1] = rly1_fn_r[5:0];
  assign code_w[otfs_pkg::T_EXT] = ext_fn_r[5:0];
  assign code_w[otfs_pkg::T_RLY2] = rly2_fn_r[5:0];
  for (genvar g = 0; g < otfs_pkg::N_TERM; g++) begin : g_term
    assign lvl_w[g] = cond_w[code_w[g]] ^ pol_w[g];
    assign def_w[g] = otfs_pkg::DEF_MASK[code_w[g]];
  end

  // Relays energise only for a defined function
  logic rly1_en_w;
  logic rly2_en_w;
  assign rly1_en_w = lvl_w[otfs_pkg::T_RLY1] & def_w[otfs_pkg::T_RLY1];
  assign rly2_en_w = lvl_w[otfs_pkg::T_RLY2] & def_w[otfs_pkg::T_RLY2];

  // Registered terminal drive
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_main_transistor_on <= 1'b0;
      o_ext_transistor_on <= 1'b0;
      o_relay_make_contact <= 1'b0;
      o_relay_break_contact <= 1'b1;
      o_relay_two_make_contact <= 1'b0;
      o_relay_two_break_contact <= 1'b1;
    end else begin
      o_main_transistor_on <= lvl_w[otfs_pkg::T_MAIN];
      o_ext_transistor_on <= lvl_w[otfs_pkg::T_EXT];
      o_relay_make_contact <= rly1_en_w;
      o_relay_break_contact <= ~rly1_en_w;
      o_relay_two_make_contact <= rly2_en_w;
      o_relay_two_break_contact <= ~rly2_en_w;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  pol_reject_a: assert property (
    (i_par_wr && hit_pol && !pol_ok_w) |=> $stable(pol_r)) else $error("bad polarity stored");
  fn_range_a: assert property (
    (main_fn_r <= otfs_pkg::FUNC_MAX) && (rly2_fn_r <= otfs_pkg::FUNC_MAX))
    else $error("function code out of range");
  code_idle_a: assert property (
    (main_fn_r[5:0] == otfs_pkg::FN_NONE) |=> (o_main_transistor_on == $past(pol_w[0])))
    else $error("code zero not idle");
  relay_rest_a: assert property (
    (rly1_fn_r[5:0] == otfs_pkg::FN_NONE) |=> (!o_relay_make_contact && o_relay_break_contact))
    else $error("idle relay not at rest");
  relay_swap_a: assert property (
    (rly2_fn_r[5:0] == otfs_pkg::FN_RUN && pol_w[3] && !i_run) |=> o_relay_two_make_contact)
    else $error("relay polarity not swapped");
  ext_invert_a: assert property (
    (ext_fn_r[5:0] == otfs_pkg::FN_UV && pol_w[2] && i_undervoltage) |=> !o_ext_transistor_on)
    else $error("negative polarity conducts");
  ready_out_a: assert property (
    (main_fn_r[5:0] == otfs_pkg::FN_READY && !pol_w[0])
    |=> (o_main_transistor_on == $past(!i_fault && i_bus_voltage_ok && !i_run_inhibit)))
    else $error("ready output wrong");
  recov_quiet_a: assert property (
    (main_fn_r[5:0] == otfs_pkg::FN_FLT_NR && !pol_w[0] && i_fault_recovery)
    |=> !o_main_transistor_on) else $error("alert during recovery");
  cnt_wrap_a: assert property (
    (cclk_rise_w && cnt_wrap_w) |=> (cnt_r == 16'h0000) && cnt_pulse_r)
    else $error("counter not reset at maximum");
endmodule
`default_nettype wire

// *** hw/otfs_pkg.sv ***
// Constants, codes and helpers for the output terminal function select block
package otfs_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned FREQ_W = 16;
  // Parameter addresses
  localparam logic [15:0] ADDR_POL = 16'h0614;
  localparam logic [15:0] ADDR_MAIN = 16'h0615;
  localparam logic [15:0] ADDR_RLY1 = 16'h0616;
  localparam logic [15:0] ADDR_EXT = 16'h0617;
  localparam logic [15:0] ADDR_RLY2 = 16'h0618;
  // Reset values
  localparam logic [15:0] RST_POL = 16'h0000;
  localparam logic [15:0] RST_MAIN = 16'h0001;
  localparam logic [15:0] RST_RLY1 = 16'h0004;
  localparam logic [15:0] RST_EXT = 16'h0000;
  localparam logic [15:0] RST_RLY2 = 16'h0000;
  // Value limits: polarity up to decimal 1111, codes up to 63
  localparam logic [15:0] POL_MAX = 16'h0457;
  localparam logic [15:0] FUNC_MAX = 16'h003F;
  // Function codes
  localparam logic [5:0] FN_NONE = 6'h00;
  localparam logic [5:0] FN_RUN = 6'h01;
  localparam logic [5:0] FN_REV = 6'h02;
  localparam logic [5:0] FN_FWD = 6'h03;
  localparam logic [5:0] FN_FLT_ALL = 6'h04;
  localparam logic [5:0] FN_FLT_NR = 6'h05;
  localparam logic [5:0] FN_EXT_FLT = 6'h06;
  localparam logic [5:0] FN_UV = 6'h07;
  localparam logic [5:0] FN_READY = 6'h08;
  localparam logic [5:0] FN_FREQ_THRESHOLD_ONE = 6'h09;
  localparam logic [5:0] FN_FREQ_THRESHOLD_TWO = 6'h0A;
  localparam logic [5:0] FN_ARRIVE = 6'h0B;
  localparam logic [5:0] FN_ZERO = 6'h0C;
  localparam logic [5:0] FN_UPPER = 6'h0D;
  localparam logic [5:0] FN_LOWER = 6'h0E;
  localparam logic [5:0] FN_CYCLE = 6'h0F;
  localparam logic [5:0] FN_PHASE = 6'h10;
  localparam logic [5:0] FN_FB_HI = 6'h11;
  localparam logic [5:0] FN_FB_LO = 6'h12;
  localparam logic [5:0] FN_FB_LOSS = 6'h13;
  localparam logic [5:0] FN_TIMER = 6'h15;
  localparam logic [5:0] FN_CNT_MAX = 6'h16;
  // Codes that have behaviour here: 1..19, 21, 22
  localparam logic [63:0] DEF_MASK = 64'h0000_0000_006F_FFFE;
  // Terminal index: main, relay one, extension, relay two
  localparam int unsigned T_MAIN = 0;
  localparam int unsigned T_RLY1 = 1;
  localparam int unsigned T_EXT = 2;
  localparam int unsigned T_RLY2 = 3;
  localparam int unsigned N_TERM = 4;
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PROG_PULSE_MS = 500;
  localparam int unsigned TIMER_PULSE_S = 1;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned TIMER_PULSE_MS = TIMER_PULSE_S * MS_PER_S;
  localparam int unsigned DEC_BASE = 10;

  // Decimal digit of v at the given place (0 units .. 3 thousands)
  function automatic int unsigned dec_digit(input logic [15:0] v, input int unsigned place);
    int unsigned x;
    x = v;
    for (int unsigned k = 0; k < place; k++) begin
      x = x / DEC_BASE;
    end
    return x % DEC_BASE;
  endfunction

  // Polarity value is legal when it is at most 1111 and every digit is 0 or 1
  function automatic logic pol_ok(input logic [15:0] v);
    logic ok;
    ok = (v <= POL_MAX);
    for (int unsigned k = 0; k < N_TERM; k++) begin
      ok = ok && (dec_digit(v, k) <= 1);
    end
    return ok;
  endfunction

  // One polarity bit per terminal from the decimal digits
  function automatic logic [3:0] pol_bits(input logic [15:0] v);
    logic [3:0] b;
    b = 4'h0;
    for (int unsigned k = 0; k < N_TERM; k++) begin
      b[k] = (dec_digit(v, k) != 0);
    end
    return b;
  endfunction
endpackage

// *** hw/otfs_pulse.sv ***
// Retriggerable fixed-width pulse timed in millisecond ticks
`timescale 1ns/10ps
`default_nettype none
module otfs_pulse #(
  parameter int unsigned WIDTH_MS = otfs_pkg::PROG_PULSE_MS
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_trig,
  input wire logic i_ms_tick,
  output logic o_active
);
  logic [15:0] cnt_r;
  logic act_r;
  logic last_w;

  // Final tick of the pulse
  assign last_w = act_r && i_ms_tick && (cnt_r == 16'(WIDTH_MS - 1));
  assign o_active = act_r;

  // Start on trigger, count ticks, stop at the width
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      act_r <= 1'b0;
      cnt_r <= 16'h0000;
    end else if (i_trig) begin
      act_r <= 1'b1;
      cnt_r <= 16'h0000;
    end else if (last_w) begin
      act_r <= 1'b0;
    end else if (act_r && i_ms_tick) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  pulse_start_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_trig |=> act_r && (cnt_r == 16'h0000)) else $error("pulse did not start");
  pulse_end_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (last_w && !i_trig) |=> !act_r) else $error("pulse did not end at width");
endmodule
`default_nettype wire

// *** hw/otfs_freq_detect.sv ***
// Frequency threshold detector with release hysteresis
`timescale 1ns/10ps
`default_nettype none
module otfs_freq_detect #(
  parameter int unsigned FW = otfs_pkg::FREQ_W
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic [FW-1:0] i_freq,
  input wire logic [FW-1:0] i_level,
  input wire logic [FW-1:0] i_hyst,
  output logic o_on
);
  logic on_r;
  logic [FW-1:0] low_w;

  // Release level saturates at zero
  assign low_w = (i_level > i_hyst) ? (i_level - i_hyst) : '0;
  assign o_on = on_r;

  // Set above level, clear below level minus hysteresis
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      on_r <= 1'b0;
    end else if (i_freq > i_level) begin
      on_r <= 1'b1;
    end else if (i_freq < low_w) begin
      on_r <= 1'b0;
    end
  end

  hyst_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (on_r && (i_freq >= low_w)) |=> on_r) else $error("released inside hysteresis band");
  thresh_set_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (i_freq > i_level) |=> on_r) else $error("not set above threshold");
endmodule
`default_nettype wire

// *** verification/otfs_load.sv ***
// Load wiring model: pulled-up transistor terminals and a lamp on relay one
`timescale 1ns/10ps
`default_nettype none
module otfs_load (
  input wire logic i_main_on,
  input wire logic i_ext_on,
  input wire logic i_make,
  input wire logic i_break,
  output logic o_y_level,
  output logic o_ext_level,
  output logic o_lamp_on
);
  // Pull-up keeps a terminal high unless its transistor conducts
  assign o_y_level = ~i_main_on;
  assign o_ext_level = ~i_ext_on;
  // Lamp lights only through a closed make contact with the break contact open
  assign o_lamp_on = i_make & ~i_break;
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for the output terminal function select block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic i_clk_sys = 1'b0, i_sys_rst = 1'b1, i_par_wr = 1'b0, i_par_rd = 1'b0;
  logic [15:0] i_par_addr = 16'h0000, i_par_wdata = 16'h0000, o_par_rdata;
  logic o_par_ack, o_par_err, i_run = 1'b0, i_reverse = 1'b0, i_fault = 1'b0;
  logic i_fault_recovery = 1'b0, i_external_fault_trip = 1'b0, i_undervoltage = 1'b0;
  logic i_bus_voltage_ok = 1'b0, i_run_inhibit = 1'b0, i_prog_cycle_done = 1'b0;
  logic i_prog_phase_done = 1'b0, i_fb_over_upper = 1'b0, i_fb_under_lower = 1'b0;
  logic i_fb_sensor_broken = 1'b0, i_timer_reached = 1'b0, i_count_clk = 1'b0;
  logic [15:0] i_out_freq = 16'h0000, i_set_freq = 16'h0000;
  logic [15:0] i_freq_upper_limit = 16'h1388, i_freq_lower_limit = 16'h0000;
  logic [15:0] i_freq_threshold_one_value = 16'h00C8;
  logic [15:0] i_freq_threshold_one_hysteresis = 16'h0064;
  logic [15:0] i_freq_threshold_two_value = 16'h0000;
  logic [15:0] i_freq_threshold_two_hysteresis = 16'h0000;
  logic [15:0] i_arrival_band_width = 16'h0000, i_feedback_loss_detect_time = 16'h0000;
  logic [15:0] i_counter_max_value = 16'h0000;
  logic o_main_transistor_on, o_ext_transistor_on, o_relay_make_contact;
  logic o_relay_break_contact, o_relay_two_make_contact, o_relay_two_break_contact;
  logic y_level, ext_level, lamp_on;
  int n_fail = 0;
  int checks = 0;
  // Status table for the main transistor: code, {run,rev,flt,rec,eft,uv,bus,inh}, level
  logic [5:0] code_tab [18] = '{6'h02, 6'h02, 6'h03, 6'h03, 6'h04, 6'h05, 6'h05, 6'h06,
    6'h07, 6'h08, 6'h08, 6'h08, 6'h0E, 6'h0D, 6'h0C, 6'h14, 6'h00, 6'h0B};
  logic [7:0] in_tab [18] = '{8'hC0, 8'h80, 8'h80, 8'hC0, 8'h10, 8'h30, 8'h20, 8'h08,
    8'h04, 8'h02, 8'h03, 8'h22, 8'h80, 8'h80, 8'h80, 8'hFF, 8'hFF, 8'h00};
  logic exp_tab [18] = '{1, 0, 1, 0, 1, 0, 1, 1, 1, 1, 0, 0, 1, 0, 1, 0, 0, 1};

  always #5 i_clk_sys = ~i_clk_sys;

  otfs_top #(.MS_CYCLES(10), .FW(16)) otfs_top_i (.*);
  otfs_load otfs_load_i (.i_main_on(o_main_transistor_on), .i_ext_on(o_ext_transistor_on),
    .i_make(o_relay_make_contact), .i_break(o_relay_break_contact),
    .o_y_level(y_level), .o_ext_level(ext_level), .o_lamp_on(lamp_on));

  // Contact pairs as {make, break}, widened for the compare task
  logic [15:0] rly1_w, rly2_w;
  assign rly1_w = {14'h0000, o_relay_make_contact, o_relay_break_contact};
  assign rly2_w = {14'h0000, o_relay_two_make_contact, o_relay_two_break_contact};

  task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask

  // One parameter access; ack and err are looked at in the cycle they stand
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d, input logic e);
    @(negedge i_clk_sys);
    i_par_wr = w;
    i_par_rd = ~w;
    i_par_addr = a;
    i_par_wdata = d;
    @(negedge i_clk_sys);
    check("ack", 16'(o_par_ack), 16'h0001);
    check("err", 16'(o_par_err), 16'(e));
    i_par_wr = 1'b0;
    i_par_rd = 1'b0;
  endtask

  task automatic t_reset();
    logic [15:0] rst_tab [5] = '{16'h0000, 16'h0001, 16'h0004, 16'h0000, 16'h0000};
    check("rly1 break", 16'(o_relay_break_contact), 16'h0001);
    for (int k = 0; k < 5; k++) begin
      acc(1'b0, 16'h0614 + 16'(k), 16'h0000, 1'b0);
      check("reset value", o_par_rdata, rst_tab[k]);
    end
    acc(1'b0, 16'h0619, 16'h0000, 1'b1);
    check("unmapped", o_par_rdata, 16'h0000);
  endtask

  task automatic t_refuse();
    acc(1'b1, 16'h0614, 16'h0002, 1'b1);
    acc(1'b1, 16'h0614, 16'h0458, 1'b1);
    acc(1'b1, 16'h0615, 16'h0040, 1'b1);
    acc(1'b1, 16'h0614, 16'h0457, 1'b0);
    acc(1'b0, 16'h0614, 16'h0000, 1'b0);
    check("pol", o_par_rdata, 16'h0457);
    acc(1'b1, 16'h0614, 16'h0000, 1'b0);
  endtask

  task automatic t_codes();
    for (int k = 0; k < 18; k++) begin
      acc(1'b1, 16'h0615, {10'h000, code_tab[k]}, 1'b0);
      {i_run, i_reverse, i_fault, i_fault_recovery, i_external_fault_trip,
        i_undervoltage, i_bus_voltage_ok, i_run_inhibit} = in_tab[k];
      tick(3);
      check("main code", 16'(o_main_transistor_on), 16'(exp_tab[k]));
    end
    {i_run, i_reverse, i_fault, i_fault_recovery, i_external_fault_trip,
      i_undervoltage, i_bus_voltage_ok, i_run_inhibit} = 8'h00;
  endtask

  task automatic t_run_pol();
    acc(1'b1, 16'h0615, 16'h0001, 1'b0);
    i_run = 1'b1;
    tick(3);
    check("y level", 16'(y_level), 16'h0000);
    acc(1'b1, 16'h0614, 16'h0001, 1'b0);
    tick(2);
    check("main inv", 16'(o_main_transistor_on), 16'h0000);
    i_run = 1'b0;
    tick(3);
    check("main idle", 16'(o_main_transistor_on), 16'h0001);
    acc(1'b1, 16'h0614, 16'h0000, 1'b0);
  endtask

  task automatic t_fdt();
    logic [15:0] f_tab [4] = '{16'h00C8, 16'h00C9, 16'h0064, 16'h0063};
    logic e_tab [4] = '{0, 1, 1, 0};
    acc(1'b1, 16'h0615, 16'h0009, 1'b0);
    for (int k = 0; k < 4; k++) begin
      i_out_freq = f_tab[k];
      tick(4);
      check("fdt", 16'(o_main_transistor_on), 16'(e_tab[k]));
    end
    i_out_freq = 16'h0000;
  endtask

  task automatic t_relay();
    i_fault = 1'b1;
    tick(3);
    check("lamp", 16'(lamp_on), 16'h0001);
    acc(1'b1, 16'h0614, 16'h000A, 1'b0);
    tick(2);
    check("rly1 inv", rly1_w, 16'h0001);
    i_fault = 1'b0;
    tick(3);
    check("rly1 rest", rly1_w, 16'h0002);
    acc(1'b1, 16'h0616, 16'h0014, 1'b0);
    tick(2);
    check("rly1 none", rly1_w, 16'h0001);
    acc(1'b1, 16'h0616, 16'h0000, 1'b0);
    tick(2);
    check("rly1 idle", rly1_w, 16'h0001);
    acc(1'b1, 16'h0618, 16'h0001, 1'b0);
    acc(1'b1, 16'h0614, 16'h03E8, 1'b0);
    tick(2);
    check("rly2 rest", rly2_w, 16'h0002);
    i_run = 1'b1;
    tick(3);
    check("rly2 run", rly2_w, 16'h0001);
    acc(1'b1, 16'h0617, 16'h0007, 1'b0);
    acc(1'b1, 16'h0614, 16'h0064, 1'b0);
    i_undervoltage = 1'b1;
    tick(3);
    check("ext inv", 16'(ext_level), 16'h0001);
    acc(1'b1, 16'h0614, 16'h0000, 1'b0);
    tick(2);
    check("ext level", 16'(ext_level), 16'h0000);
    i_undervoltage = 1'b0;
    i_run = 1'b0;
  endtask

  // Feedback alarm after a 3 ms persistence, then sensor loss
  task automatic t_fb();
    acc(1'b1, 16'h0615, 16'h0011, 1'b0);
    i_feedback_loss_detect_time = 16'h0003;
    i_fb_over_upper = 1'b1;
    tick(3);
    check("fb early", 16'(o_main_transistor_on), 16'h0000);
    tick(40);
    check("fb high", 16'(o_main_transistor_on), 16'h0001);
    i_fb_over_upper = 1'b0;
    acc(1'b1, 16'h0615, 16'h0013, 1'b0);
    i_fb_sensor_broken = 1'b1;
    tick(3);
    check("fb loss", 16'(o_main_transistor_on), 16'h0001);
    i_fb_sensor_broken = 1'b0;
  endtask

  // Count clock edges up to a maximum of 3; pulse lasts one count period
  task automatic t_count();
    i_counter_max_value = 16'h0003;
    acc(1'b1, 16'h0615, 16'h0016, 1'b0);
    for (int k = 0; k < 3; k++) begin
      check("cnt idle", 16'(o_main_transistor_on), 16'h0000);
      i_count_clk = 1'b1;
      tick(8);
      i_count_clk = 1'b0;
      tick(8);
    end
    check("cnt max", 16'(o_main_transistor_on), 16'h0001);
    i_count_clk = 1'b1;
    tick(8);
    check("cnt reset", 16'(o_main_transistor_on), 16'h0000);
    i_count_clk = 1'b0;
  endtask

  // Event pulses on the main transistor with a 10-cycle millisecond tick
  task automatic t_pulse(input logic [5:0] code, input int sel, input int width_ms);
    acc(1'b1, 16'h0615, {10'h000, code}, 1'b0);
    tick(1);
    i_prog_cycle_done = (sel == 0);
    i_prog_phase_done = (sel == 1);
    i_timer_reached = (sel == 2);
    tick(1);
    {i_prog_cycle_done, i_prog_phase_done, i_timer_reached} = 3'h0;
    tick(3);
    check("pulse start", 16'(o_main_transistor_on), 16'h0001);
    tick(width_ms * 10 - 150);
    check("pulse held", 16'(o_main_transistor_on), 16'h0001);
    tick(200);
    check("pulse end", 16'(o_main_transistor_on), 16'h0000);
  endtask

  task automatic end_of_test();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    tick(4);
    i_sys_rst = 1'b0;
    tick(2);
    t_reset();
    t_refuse();
    t_codes();
    t_run_pol();
    t_fdt();
    t_relay();
    t_fb();
    t_count();
    t_pulse(6'h0F, 0, 500);
    t_pulse(6'h10, 1, 500);
    t_pulse(6'h15, 2, 1000);
    end_of_test();
  end
endmodule
`default_nettype wire
